// [src/aod_decode_flags.sv]
module aod_decode_flags (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction request from the fetch side
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] dst_field,
  input wire logic [7:0] src_field,
  // operand values already read by the fetch side
  input wire logic [7:0] dst_value,
  input wire logic [7:0] src_value,
  // flag vector as held by the core (c z s v d h x x)
  input wire logic [7:0] flags_in,
  // decoded addressing mode and operand classification
  output logic legal,
  output logic [2:0] addr_pair,
  output logic dst_is_work,
  output logic [3:0] dst_work_num,
  output logic src_is_work,
  output logic [3:0] src_work_num,
  output logic dst_reg_ok,
  output logic src_reg_ok,
  // result and flag update
  output logic done,
  output logic write_dst,
  output logic [7:0] result,
  output logic [7:0] flags_out
);

  // ------------------------------------------------------------
  // combinational decode
  // ------------------------------------------------------------
  // everything here depends only on the request of this cycle;
  // nothing is stored until the registered stages further down
  logic [3:0] op_hi; // operation nibble
  logic [3:0] op_lo; // addressing nibble
  logic op_known; // operation nibble is one of the group
  logic mode_known; // addressing nibble is one of the six pairs
  logic [2:0] next_pair; // index of the addressing pair
  logic next_dst_work; // destination field names a working register
  logic next_src_work; // source field names a working register
  logic next_dst_ok;
  logic next_src_ok;

  // the two nibbles are decoded independently of each other
  assign op_hi = opcode[7:4];
  assign op_lo = opcode[3:0];

  // operation nibble check
  // nibbles 8, 9 and c to f belong to other groups and are refused
  always_comb begin
    case (op_hi)
      aod_pkg::OP_ADD, aod_pkg::OP_ADD_CARRY, aod_pkg::OP_SUB,
      aod_pkg::OP_MINUS_WITH_BORROW, aod_pkg::OP_OR, aod_pkg::OP_AND,
      aod_pkg::OP_TEST_COMPLEMENT_UNDER_MASK, aod_pkg::OP_TEST_UNDER_MASK,
      aod_pkg::OP_COMPARE_OP, aod_pkg::OP_XOR: op_known = 1'b1;
      default: op_known = 1'b0;
    endcase
  end

  // addressing pair decode; pair index runs 0..5 for nibbles 2..7
  // pairs 0 and 1 carry both operands as compact working numbers,
  // pairs 2 and 3 carry full register fields, pairs 4 and 5 a literal
  always_comb begin
    // defaults keep the decode free of latches
    mode_known = 1'b1;
    next_pair = 3'h0;
    case (op_lo)
      aod_pkg::AM_WORK_WORK: next_pair = 3'h0;
      aod_pkg::AM_WORK_POINTER_VIA_WORK_REG: next_pair = 3'h1;
      aod_pkg::AM_REG_REG: next_pair = 3'h2;
      aod_pkg::AM_REG_POINTER_VIA_ANY_REG: next_pair = 3'h3;
      aod_pkg::AM_REG_LITERAL_OPERAND: next_pair = 3'h4;
      aod_pkg::AM_POINTER_VIA_ANY_REG_LITERAL: next_pair = 3'h5;
      // any other nibble belongs to another instruction group
      default: mode_known = 1'b0;
    endcase
  end

  // operand fields: compact pairs always name working registers; full
  // fields name one when their upper nibble is the prefix
  // the range checks only flag a field; the core decides what to do with it
  always_comb begin
    next_dst_work = (next_pair < 3'h2) || (dst_field[7:4] == aod_pkg::WORK_REG_PREFIX);
    // a literal source is data, never a register
    next_src_work = (next_pair < 3'h2) ||
                    ((next_pair < 3'h4) && (src_field[7:4] == aod_pkg::WORK_REG_PREFIX));
    // outside 128..239 except working prefix; compact fields are always fine
    next_dst_ok = next_dst_work || (dst_field <= aod_pkg::REG_LOW_TOP) ||
                  (dst_field >= aod_pkg::REG_HIGH_BASE);
    // a literal source has no address, so it can never be out of range
    next_src_ok = (next_pair >= 3'h4) || next_src_work || (src_field <= aod_pkg::REG_LOW_TOP) ||
                  (src_field >= aod_pkg::REG_HIGH_BASE);
  end

  // ------------------------------------------------------------
  // arithmetic and logic
  // ------------------------------------------------------------
  // the adder sees the operand values the fetch side has already read;
  // this block never addresses the register file itself
  logic [8:0] next_sum; // nine bits keep the carry out of bit seven
  logic [4:0] next_low; // low nibble sum, bit four is the half carry
  logic [7:0] next_res;
  logic [7:0] next_flags;
  logic carry_in;
  logic is_sub;
  logic [7:0] addend; // source as presented to the adder

  // subtraction reuses the adder with inverted source; borrow = not carry
  // one adder for the whole group keeps the carry chain shared;
  // the price is that subtract flags are inverted after the sum
  always_comb begin
    is_sub = (op_hi == aod_pkg::OP_SUB) || (op_hi == aod_pkg::OP_MINUS_WITH_BORROW) ||
             (op_hi == aod_pkg::OP_COMPARE_OP);
    addend = is_sub ? ~src_value : src_value;
    case (op_hi)
      aod_pkg::OP_ADD_CARRY: carry_in = flags_in[aod_pkg::FLAG_C];
      aod_pkg::OP_MINUS_WITH_BORROW: carry_in = ~flags_in[aod_pkg::FLAG_C];
      aod_pkg::OP_SUB, aod_pkg::OP_COMPARE_OP: carry_in = 1'b1;
      default: carry_in = 1'b0;
    endcase
    // two's complement sum; src_value is only read, never driven back
    next_sum = {1'b0, dst_value} + {1'b0, addend} + {8'h00, carry_in};
    next_low = {1'b0, dst_value[3:0]} + {1'b0, addend[3:0]} + {4'h0, carry_in};
  end

  // result and flag selection per operation
  // flags start from the core's copy so that every flag an operation
  // leaves alone passes through unchanged, bits one and zero included
  always_comb begin
    next_flags = flags_in;
    case (op_hi)
      aod_pkg::OP_OR: next_res = dst_value | src_value;
      aod_pkg::OP_AND, aod_pkg::OP_TEST_UNDER_MASK: next_res = dst_value & src_value;
      aod_pkg::OP_TEST_COMPLEMENT_UNDER_MASK: next_res = ~dst_value & src_value;
      aod_pkg::OP_XOR: next_res = dst_value ^ src_value;
      default: next_res = next_sum[7:0];
    endcase
    // zero and sign follow every operation of the group
    next_flags[aod_pkg::FLAG_Z] = (next_res == 8'h00);
    next_flags[aod_pkg::FLAG_S] = next_res[7];
    if ((op_hi == aod_pkg::OP_ADD) || (op_hi == aod_pkg::OP_ADD_CARRY) || is_sub) begin
      next_flags[aod_pkg::FLAG_C] = is_sub ? ~next_sum[8] : next_sum[8];
      // like-signed inputs to the adder, opposite-signed result
      next_flags[aod_pkg::FLAG_V] = (dst_value[7] == addend[7]) &&
                                    (next_res[7] != dst_value[7]);
      if (op_hi != aod_pkg::OP_COMPARE_OP) begin
        // compare leaves decimal-adjust and half carry alone
        next_flags[aod_pkg::FLAG_D] = is_sub;
        next_flags[aod_pkg::FLAG_H] = is_sub ? ~next_low[4] : next_low[4];
      end
    end else begin
      // logic forms clear overflow; carry, decimal-adjust and half carry unaffected
      next_flags[aod_pkg::FLAG_V] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // registered decode outputs
  // ------------------------------------------------------------
  // decode outputs change only when a request is taken and then hold,
  // so the core can read them at any time until the next request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      legal <= 1'b0;
      addr_pair <= 3'h0;
      dst_is_work <= 1'b0;
      dst_work_num <= 4'h0;
      src_is_work <= 1'b0;
      src_work_num <= 4'h0;
      dst_reg_ok <= 1'b0;
      src_reg_ok <= 1'b0;
    end else if (op_valid) begin
      legal <= op_known && mode_known;
      addr_pair <= next_pair;
      dst_is_work <= next_dst_work;
      dst_work_num <= dst_field[3:0];
      src_is_work <= next_src_work;
      src_work_num <= src_field[3:0];
      dst_reg_ok <= next_dst_ok;
      src_reg_ok <= next_src_ok;
    end
  end

  // ------------------------------------------------------------
  // registered result, flags and write strobe
  // ------------------------------------------------------------
  // an illegal opcode completes without touching flags or destination
  // done answers every request exactly one cycle later, legal or not,
  // so the fetch side never waits on a request that was refused
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done <= 1'b0;
      write_dst <= 1'b0;
      result <= aod_pkg::RESULT_RESET;
      flags_out <= aod_pkg::FLAGS_RESET;
    end else begin
      // write strobe and done are one-cycle pulses
      done <= op_valid;
      write_dst <= 1'b0;
      if (op_valid && op_known && mode_known) begin
        result <= next_res;
        flags_out <= next_flags;
        // compare and both tests are flag-only
        write_dst <= (op_hi != aod_pkg::OP_COMPARE_OP) &&
                     (op_hi != aod_pkg::OP_TEST_UNDER_MASK) &&
                     (op_hi != aod_pkg::OP_TEST_COMPLEMENT_UNDER_MASK);
      end else if (op_valid) begin
        // refused: flags pass through, result keeps its last value
        flags_out <= flags_in;
      end
    end
  end

endmodule

// [src/aod_pkg.sv]
package aod_pkg;

  // ------------------------------------------------------------
  // operation codes carried in the high opcode nibble
  // ------------------------------------------------------------
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_ADD_CARRY = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_MINUS_WITH_BORROW = 4'h3;
  localparam logic [3:0] OP_OR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_TEST_COMPLEMENT_UNDER_MASK = 4'h6;
  localparam logic [3:0] OP_TEST_UNDER_MASK = 4'h7;
  localparam logic [3:0] OP_COMPARE_OP = 4'ha;
  localparam logic [3:0] OP_XOR = 4'hb;

  // ------------------------------------------------------------
  // addressing pairs carried in the low opcode nibble
  // ------------------------------------------------------------
  localparam logic [3:0] AM_WORK_WORK = 4'h2;
  localparam logic [3:0] AM_WORK_POINTER_VIA_WORK_REG = 4'h3;
  localparam logic [3:0] AM_REG_REG = 4'h4;
  localparam logic [3:0] AM_REG_POINTER_VIA_ANY_REG = 4'h5;
  localparam logic [3:0] AM_REG_LITERAL_OPERAND = 4'h6;
  localparam logic [3:0] AM_POINTER_VIA_ANY_REG_LITERAL = 4'h7;

  // ------------------------------------------------------------
  // register field layout and ranges
  // ------------------------------------------------------------
  localparam logic [3:0] WORK_REG_PREFIX = 4'he;
  localparam logic [7:0] REG_LOW_TOP = 8'h7f;
  localparam logic [7:0] REG_HIGH_BASE = 8'hf0;

  // ------------------------------------------------------------
  // flag bit positions in the flag vector and reset values
  // ------------------------------------------------------------
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;

endpackage

// [test/aod_checks_assertions.sv]
module aod_checks (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request as presented to the block
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] dst_field,
  input wire logic [7:0] dst_value,
  input wire logic [7:0] src_value,
  input wire logic [7:0] flags_in,
  // answers driven by the block
  input wire logic legal,
  input wire logic [2:0] addr_pair,
  input wire logic dst_is_work,
  input wire logic dst_reg_ok,
  input wire logic done,
  input wire logic write_dst,
  input wire logic [7:0] result,
  input wire logic [7:0] flags_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic leg, tst, hc, vc, wk, dok;
  logic [2:0] pr;
  logic [8:0] s9;
  // reference decode of the presented request
  assign leg = (opcode[7:4] <= 4'h7 || opcode[7:4] == 4'ha || opcode[7:4] == 4'hb) && opcode[3:0] >= 4'h2
    && opcode[3:0] <= 4'h7;
  assign tst = opcode[7:4] == 4'h6 || opcode[7:4] == 4'h7 || opcode[7:4] == 4'ha;
  assign pr = opcode[2:0] - 3'h2;
  assign wk = dst_field[7:4] == 4'he;
  assign dok = opcode[3:1] == 3'h1 || dst_field < 8'h80 || dst_field >= 8'hf0 || wk;
  // nine-bit sum keeps the carry out of bit seven visible
  assign s9 = {1'b0, dst_value} + {1'b0, src_value} + {8'h00, flags_in[7]};
  assign hc = ({1'b0, dst_value[3:0]} + {1'b0, src_value[3:0]} + {4'h0, flags_in[7]}) > 5'h0f;
  assign vc = dst_value[7] == src_value[7] && s9[7] != dst_value[7];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_adc;
    op_valid && leg && opcode[7:4] == 4'h1;
  endsequence
  a_done_follows: assert property (op_valid |=> done) else $error("done missing");
  a_done_cause: assert property (done |-> $past(op_valid)) else $error("stray done");
  a_legal_map: assert property (op_valid |=> legal == $past(leg)) else $error("legal wrong");
  a_pair_map: assert property (op_valid && leg |=> addr_pair == $past(pr)) else $error("pair wrong");
  a_write_kind: assert property (op_valid |=> write_dst == $past(leg && !tst)) else $error("write wrong");
  a_adc_sum: assert property (s_adc |=> result == $past(s9[7:0])) else $error("sum wrong");
  a_adc_carry: assert property (s_adc |=> flags_out[7] == $past(s9[8])) else $error("carry wrong");
  a_adc_zs: assert property (s_adc |=> flags_out[6:5] == {$past(s9[7:0]) == 8'h00, $past(s9[7])})
    else $error("z s wrong");
  a_adc_ovf: assert property (s_adc |=> flags_out[4] == $past(vc)) else $error("overflow wrong");
  a_adc_dh: assert property (s_adc |=> flags_out[3:2] == {1'b0, $past(hc)}) else $error("d h wrong");
  a_work_det: assert property (op_valid && leg && opcode[3:0] >= 4'h4 |=> dst_is_work == $past(wk))
    else $error("work detect wrong");
  a_reg_range: assert property (op_valid && leg |=> dst_reg_ok == $past(dok)) else $error("range wrong");
endmodule

// [test/aod_prog_mem.sv]
module aod_prog_mem (
  // fetch control from the bench
  input wire logic en,
  input wire logic [1:0] sel,
  input wire logic [7:0] opc_in,
  // bytes as the memory presents them
  output logic [7:0] opcode,
  output logic [7:0] dst_field,
  output logic [7:0] src_field,
  output logic [7:0] dst_value,
  output logic [7:0] src_value
);
  timeunit 1ns;
  timeprecision 1ps;
  // operand bytes: dst field, src field, dst value, src value
  logic [31:0] rom [4] = '{32'h10141620, 32'he5807f00, 32'h05f3ff00, 32'h200f3c0f};
  logic [31:0] w;
  // bytes read back inverted outside a fetch, so stale values never look valid
  assign w = en ? rom[sel] : ~rom[sel];
  assign opcode = en ? opc_in : ~opc_in;
  assign {dst_field, src_field, dst_value, src_value} = w;
endmodule

// [test/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, en = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] opc = 8'h00, flags_in = 8'h00;
  logic [7:0] opcode, dst_field, src_field, dst_value, src_value, result, flags_out;
  logic legal, dst_is_work, src_is_work, dst_reg_ok, src_reg_ok, done, write_dst;
  logic [2:0] addr_pair;
  logic [3:0] dst_work_num, src_work_num;
  int err_count = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  aod_prog_mem pm (.en(en), .sel(sel), .opc_in(opc), .opcode(opcode), .dst_field(dst_field),
    .src_field(src_field), .dst_value(dst_value), .src_value(src_value));
  aod_decode_flags uut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .opcode(opcode), .dst_field(dst_field),
    .src_field(src_field), .dst_value(dst_value), .src_value(src_value), .flags_in(flags_in), .legal(legal),
    .addr_pair(addr_pair), .dst_is_work(dst_is_work), .dst_work_num(dst_work_num), .src_is_work(src_is_work),
    .src_work_num(src_work_num), .dst_reg_ok(dst_reg_ok), .src_reg_ok(src_reg_ok), .done(done),
    .write_dst(write_dst), .result(result), .flags_out(flags_out));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one request held for a single edge, answer looked at one cycle on
  task issue(input logic [7:0] op, input logic [1:0] s, input logic [7:0] f);
    @(posedge clk);
    op_valid <= 1'b1;
    en <= 1'b1;
    opc <= op;
    sel <= s;
    flags_in <= f;
    @(posedge clk);
    op_valid <= 1'b0;
    en <= 1'b0;
    #1;
    chk({7'h00, done}, 8'h01);
  endtask
  task t_adc;
    issue(8'h12, 2'h0, 8'h80);
    chk(result, 8'h37);
    chk(flags_out, 8'h00);
    chk({3'h0, legal, write_dst, addr_pair}, 8'h18);
    chk({3'h0, src_is_work, src_work_num}, 8'h14);
    issue(8'h14, 2'h1, 8'h8c);
    chk(result, 8'h80);
    chk(flags_out, 8'h34);
    chk({3'h0, dst_is_work, dst_work_num}, 8'h15);
    chk({6'h00, dst_reg_ok, src_reg_ok}, 8'h02);
    issue(8'h14, 2'h2, 8'h81);
    chk(result, 8'h00);
    chk(flags_out, 8'hc5);
    chk({6'h00, dst_reg_ok, src_reg_ok}, 8'h03);
  endtask
  // every operation; flag-only forms still show their value, only the write strobe stays low
  task t_ops;
    logic [7:0] res [10];
    logic [7:0] fl [10];
    logic [3:0] hi [10];
    res = '{8'h4b, 8'h4b, 8'h2d, 8'h2d, 8'h3f, 8'h0c, 8'h03, 8'h0c, 8'h2d, 8'h33};
    fl = '{8'h04, 8'h04, 8'h0c, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    hi = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'ha, 4'hb};
    for (int i = 0; i < 10; i++) begin
      issue({hi[i], 4'h6}, 2'h3, 8'h00);
      chk(result, res[i]);
      chk(flags_out, fl[i]);
      chk({6'h00, legal, write_dst}, {6'h00, 1'b1, i < 6 || i == 9});
    end
  endtask
  task t_pairs;
    for (int n = 0; n < 10; n++) begin
      issue({4'h1, n[3:0]}, 2'h3, 8'ha5);
      if (n >= 2 && n <= 7) begin
        chk({5'h00, addr_pair}, n[7:0] - 8'h02);
        chk({7'h00, dst_is_work}, {7'h00, n < 4});
        chk({7'h00, src_is_work}, {7'h00, n < 4});
        chk(result, 8'h4c);
      end else begin
        chk({6'h00, legal, write_dst}, 8'h00);
        chk(result, (n < 2) ? 8'h33 : 8'h4c);
        chk(flags_out, 8'ha5);
      end
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(result | flags_out, 8'h00);
    t_adc();
    t_ops();
    t_pairs();
    results();
  end
endmodule
bind aod_decode_flags aod_checks chk_i (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .legal(legal),
  .dst_is_work(dst_is_work), .dst_reg_ok(dst_reg_ok), .done(done), .write_dst(write_dst), .opcode(opcode),
  .dst_field(dst_field), .dst_value(dst_value), .src_value(src_value), .flags_in(flags_in), .result(result),
  .flags_out(flags_out), .addr_pair(addr_pair));
